// [logic/omsc_top.sv]
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module omsc_top #(
  parameter int                  SETTLE_CYC = omsc_pkg::OMSC_SETTLE_CYC,
  parameter omsc_pkg::omsc_mode_t MODE_RST  = omsc_pkg::OMSC_MODE_MED
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               crystal_input_pin,
  input  wire logic               power_up_delay_done,
  input  wire logic               sleep_enter,
  input  wire logic               wake_req,
  input  wire logic               fast_osc_ready,
  input  wire logic               slow_osc_ready,
  input  wire logic               fast_osc_tick,
  input  wire logic               slow_osc_tick,
  output omsc_pkg::omsc_pad_t     clock_input_pad,
  output omsc_pkg::omsc_pad_t     crystal_output_pad,
  output omsc_pkg::omsc_gain_t    gain_select,
  output logic                    core_run,
  output logic                    sys_clk_internal,
  output logic                    fast_osc_enable,
  output logic                    slow_osc_enable,
  output logic [4:0]              trim_value
);
  import omsc_pkg::*;

  localparam int CW = $clog2(SETTLE_CYC);

  typedef enum logic [3:0] {
    ST_DELAY = 4'b0001,
    ST_COUNT = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_SLEEP = 4'b1000
  } omsc_state_t;

  function automatic logic is_crystal(input omsc_mode_t m);
    is_crystal = (m == OMSC_MODE_LOW) || (m == OMSC_MODE_MED) ||
                 (m == OMSC_MODE_HIGH);
  endfunction

  function automatic logic [6:0] post_mask(input logic [2:0] sel);
    post_mask = 7'h7F >> sel;
  endfunction

  omsc_state_t   state_q;
  omsc_mode_t    mode_q;
  logic [CW-1:0] cnt_q;
  logic [2:0]    ifs_q;
  logic          scs_q;
  logic          tss_q;
  logic          power_up_delay_timer_q;
  logic [4:0]    trim_q;
  logic [6:0]    post_q;
  logic          xin_lvl;
  logic          xin_prev_q;
  logic          wake_lvl;
  logic          wake_prev_q;
  logic          fast_rdy;
  logic          slow_rdy;
  logic          xin_edge;
  logic          wake_edge;
  logic          int_tick;
  logic          quarter;
  logic          quarter_en;
  logic          crystal;
  logic          fast_internal_stable_flag;
  logic          slow_internal_stable_flag;
  logic          startup_complete_flag;
  logic          wr_en;
  logic          rd_take;
  logic          mapped;
  logic [31:0]   rd_word;

  omsc_sync u_xin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (crystal_input_pin),
    .level_q  (xin_lvl)
  );

  omsc_sync u_wake_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (wake_req),
    .level_q  (wake_lvl)
  );

  omsc_sync u_fast_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (fast_osc_ready),
    .level_q  (fast_rdy)
  );

  omsc_sync u_slow_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (slow_osc_ready),
    .level_q  (slow_rdy)
  );

  // Rising edges of the filtered pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xin_prev_q  <= 1'b0;
      wake_prev_q <= 1'b0;
    end else begin
      xin_prev_q  <= xin_lvl;
      wake_prev_q <= wake_lvl;
    end
  end

  assign xin_edge  = xin_lvl & ~xin_prev_q;
  assign wake_edge = wake_lvl & ~wake_prev_q;
  assign crystal   = is_crystal(mode_q);

  // APB slave: one wait state, write and read at the pready edge
  assign wr_en   = psel & penable & pready & pwrite;
  assign rd_take = psel & penable & ~pready;
  assign mapped  = (paddr == OMSC_CTRL_OFS) || (paddr == OMSC_TRIM_OFS) ||
                   (paddr == OMSC_CFG_OFS);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      OMSC_CTRL_OFS: begin
        rd_word[OMSC_IFS_LSB +: 3] = ifs_q;
        rd_word[OMSC_STARTUP_COMPLETE_FLAG_BIT]     = startup_complete_flag;
        rd_word[OMSC_HTS_BIT]      = fast_internal_stable_flag;
        rd_word[OMSC_LTS_BIT]      = slow_internal_stable_flag;
        rd_word[OMSC_SCS_BIT]      = scs_q;
      end
      OMSC_TRIM_OFS: begin
        rd_word[4:0] = trim_q;
      end
      OMSC_CFG_OFS: begin
        rd_word[OMSC_MODE_LSB +: 3] = mode_q;
        rd_word[OMSC_TSS_BIT]       = tss_q;
        rd_word[OMSC_POWER_UP_DELAY_TIMER_BIT]      = power_up_delay_timer_q;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_take;
      if (rd_take) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control register: frequency select and clock select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifs_q <= OMSC_IFS_RST;
      scs_q <= 1'b0;
    end else if (wr_en && paddr == OMSC_CTRL_OFS) begin
      ifs_q <= pwdata[OMSC_IFS_LSB +: 3];
      scs_q <= pwdata[OMSC_SCS_BIT];
    end
  end

  // Trim register; takes effect on the fast source with no done flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q <= OMSC_TRIM_RST;
    end else if (wr_en && paddr == OMSC_TRIM_OFS) begin
      trim_q <= pwdata[4:0];
    end
  end

  // Configuration register; the mode drives gain, pins and clock source from the next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
      tss_q  <= 1'b0;
      power_up_delay_timer_q <= 1'b0;
    end else if (wr_en && paddr == OMSC_CFG_OFS) begin
      mode_q <= omsc_mode_t'(pwdata[OMSC_MODE_LSB +: 3]);
      tss_q  <= pwdata[OMSC_TSS_BIT];
      power_up_delay_timer_q <= pwdata[OMSC_POWER_UP_DELAY_TIMER_BIT];
    end
  end

  // Start-up sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_DELAY;
    end else begin
      case (state_q)
        ST_DELAY: begin
          if (!crystal) begin
            state_q <= ST_RUN;
          end else if (!power_up_delay_timer_q || power_up_delay_done) begin
            state_q <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (xin_edge && cnt_q == CW'(SETTLE_CYC - 1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (sleep_enter) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_edge) begin
            state_q <= crystal ? ST_COUNT : ST_RUN;
          end
        end
        default: begin
          state_q <= ST_DELAY;
        end
      endcase
    end
  end

  // Settle counter: counts crystal input oscillations only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (state_q != ST_COUNT) begin
      cnt_q <= '0;
    end else if (xin_edge) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Postscaler on the fast source; zero select picks the slow one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_q <= 7'h00;
    end else if (fast_osc_tick) begin
      post_q <= post_q + 7'h01;
    end
  end

  always_comb begin
    if (ifs_q == 3'h0) begin
      int_tick = slow_osc_tick;
    end else begin
      int_tick = fast_osc_tick &&
                 ((post_q & post_mask(ifs_q)) == post_mask(ifs_q));
    end
  end

  assign quarter_en = (mode_q == OMSC_MODE_RCD) || (mode_q == OMSC_MODE_INTQ);

  omsc_div4 u_quarter (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (quarter_en),
    .tick      ((mode_q == OMSC_MODE_RCD) ? xin_edge : int_tick),
    .quarter_q (quarter)
  );

  assign fast_internal_stable_flag  = fast_rdy & fast_osc_enable;
  assign slow_internal_stable_flag  = slow_rdy & slow_osc_enable;
  assign startup_complete_flag = (state_q == ST_RUN) & ~sys_clk_internal;

  // Oscillator enables and source select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_enable  <= 1'b0;
      slow_osc_enable  <= 1'b0;
      sys_clk_internal <= 1'b0;
    end else begin
      fast_osc_enable  <= (ifs_q != 3'h0) && (scs_q || tss_q);
      slow_osc_enable  <= ((ifs_q == 3'h0) && (scs_q || tss_q)) || power_up_delay_timer_q;
      sys_clk_internal <= scs_q || (mode_q == OMSC_MODE_INTQ) ||
                          (mode_q == OMSC_MODE_INTF);
    end
  end

  // Trim goes to the fast source only; the slow source has no trim input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_value <= OMSC_TRIM_RST;
    end else begin
      trim_value <= trim_q;
    end
  end

  // Core release; low outside ST_RUN and while sleep_enter is high, and no clock is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_run <= 1'b0;
    end else begin
      core_run <= (state_q == ST_RUN) && !sleep_enter;
    end
  end

  // Amplifier gain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_select <= OMSC_GAIN_OFF;
    end else begin
      case (mode_q)
        OMSC_MODE_LOW:  gain_select <= OMSC_GAIN_LOW;
        OMSC_MODE_MED:  gain_select <= OMSC_GAIN_MED;
        OMSC_MODE_HIGH: gain_select <= OMSC_GAIN_HIGH;
        default:        gain_select <= OMSC_GAIN_OFF;
      endcase
    end
  end

  // Pin ownership per clock mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_input_pad    <= '0;
      crystal_output_pad <= '0;
    end else begin
      clock_input_pad    <= '0;
      crystal_output_pad <= '0;
      case (mode_q)
        OMSC_MODE_EXT: begin
          crystal_output_pad.gpio_free <= 1'b1;
        end
        OMSC_MODE_RCD: begin
          crystal_output_pad.out <= quarter;
          crystal_output_pad.oe  <= 1'b1;
        end
        OMSC_MODE_RCF: begin
          crystal_output_pad.gpio_free <= 1'b1;
        end
        OMSC_MODE_INTQ: begin
          clock_input_pad.gpio_free <= 1'b1;
          crystal_output_pad.out    <= quarter;
          crystal_output_pad.oe     <= 1'b1;
        end
        OMSC_MODE_INTF: begin
          clock_input_pad.gpio_free    <= 1'b1;
          crystal_output_pad.gpio_free <= 1'b1;
        end
        default: begin
          crystal_output_pad <= '0;
        end
      endcase
    end
  end
endmodule

// [logic/omsc_pkg.sv]
package omsc_pkg;

  // Register byte offsets
  localparam logic [7:0] OMSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] OMSC_TRIM_OFS = 8'h04;
  localparam logic [7:0] OMSC_CFG_OFS  = 8'h08;

  // Control register field positions
  localparam int OMSC_SCS_BIT  = 0;
  localparam int OMSC_LTS_BIT  = 1;
  localparam int OMSC_HTS_BIT  = 2;
  localparam int OMSC_STARTUP_COMPLETE_FLAG_BIT = 3;
  localparam int OMSC_IFS_LSB  = 4;

  // Configuration register field positions
  localparam int OMSC_MODE_LSB = 0;
  localparam int OMSC_TSS_BIT  = 3;
  localparam int OMSC_POWER_UP_DELAY_TIMER_BIT = 4;

  // Values after reset
  localparam logic [2:0] OMSC_IFS_RST  = 3'h6;
  localparam logic [4:0] OMSC_TRIM_RST = 5'h00;

  // Settle count in crystal oscillations
  localparam int OMSC_SETTLE_CYC = 1024;

  typedef enum logic [2:0] {
    OMSC_MODE_EXT  = 3'h0,
    OMSC_MODE_LOW  = 3'h1,
    OMSC_MODE_MED  = 3'h2,
    OMSC_MODE_HIGH = 3'h3,
    OMSC_MODE_RCD  = 3'h4,
    OMSC_MODE_RCF  = 3'h5,
    OMSC_MODE_INTQ = 3'h6,
    OMSC_MODE_INTF = 3'h7
  } omsc_mode_t;

  typedef enum logic [1:0] {
    OMSC_GAIN_OFF  = 2'h0,
    OMSC_GAIN_LOW  = 2'h1,
    OMSC_GAIN_MED  = 2'h2,
    OMSC_GAIN_HIGH = 2'h3
  } omsc_gain_t;

  // One oscillator pad: data out, enable, and free for general I/O
  typedef struct packed {
    logic out;
    logic oe;
    logic gpio_free;
  } omsc_pad_t;

endpackage

// [logic/omsc_sync.sv]
`timescale 1ns/100ps
module omsc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      level_q
);
  import omsc_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change counts once the second and third stage agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule

// [logic/omsc_div4.sv]
`timescale 1ns/100ps
module omsc_div4 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic tick,
  output logic      quarter_q
);
  import omsc_pkg::*;

  logic [1:0] cnt_q;

  // Two input ticks per half period give a quarter rate square wave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
    end else if (!enable) begin
      cnt_q <= 2'h0;
    end else if (tick) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quarter_q <= 1'b0;
    end else begin
      quarter_q <= enable & cnt_q[1];
    end
  end
endmodule

// [dv/omsc_checker.sv]
`timescale 1ns/100ps
module omsc_checker #(
  parameter int                   SETTLE_CYC = 1024,
  parameter omsc_pkg::omsc_mode_t MODE_RST   = omsc_pkg::OMSC_MODE_MED
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic                 pready,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 crystal_input_pin,
  input wire logic                 sleep_enter,
  input wire logic                 wake_req,
  input wire omsc_pkg::omsc_pad_t  clock_input_pad,
  input wire omsc_pkg::omsc_pad_t  crystal_output_pad,
  input wire omsc_pkg::omsc_gain_t gain_select,
  input wire logic                 core_run,
  input wire logic                 sys_clk_internal,
  input wire logic                 fast_osc_enable
);
  import omsc_pkg::*;
  logic       wr, wake, live_q, slp_q, xtal_q, wake_q, scs_q, tss_q;
  logic [2:0] mode_q, ifs_q;
  int         edges_q;
  assign wr   = psel && penable && pready && pwrite;
  assign wake = wake_req && !wake_q;
  // Shadow of the control and configuration fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scs_q, tss_q, ifs_q, mode_q} <= {2'h0, OMSC_IFS_RST, MODE_RST};
    end else if (wr) begin
      if (paddr == OMSC_CTRL_OFS) {ifs_q, scs_q} <= {pwdata[6:4], pwdata[0]};
      if (paddr == OMSC_CFG_OFS) {tss_q, mode_q} <= pwdata[3:0];
    end
  end
  // Sleep state and crystal edges seen since reset or wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {live_q, slp_q, xtal_q, wake_q} <= 4'h0;
      edges_q <= 0;
    end else begin
      live_q <= 1'b1;
      xtal_q <= crystal_input_pin;
      wake_q <= wake_req;
      if (wake) slp_q <= 1'b0;
      else if (sleep_enter && core_run) slp_q <= 1'b1;
      if (core_run || wake) edges_q <= 0;
      else if (crystal_input_pin && !xtal_q) edges_q <= edges_q + 1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cfg_still;
    live_q && $stable(mode_q);
  endsequence
  sequence s_sleep_req;
    sleep_enter && core_run;
  endsequence
  chk_gain_mode: assert property (s_cfg_still |->
    gain_select == ((mode_q inside {[3'h1:3'h3]}) ? omsc_gain_t'(mode_q[1:0]) : OMSC_GAIN_OFF))
    else $error("gain select wrong for mode");
  chk_outpin_free: assert property (s_cfg_still |->
    crystal_output_pad.gpio_free == (mode_q inside {3'h0, 3'h5, 3'h7}))
    else $error("output pin release wrong");
  chk_inpin_free: assert property (s_cfg_still |->
    clock_input_pad.gpio_free == (mode_q inside {3'h6, 3'h7}))
    else $error("input pin release wrong");
  chk_outpin_drive: assert property (s_cfg_still |->
    crystal_output_pad.oe == (mode_q inside {3'h4, 3'h6}))
    else $error("output pin drive wrong");
  chk_settle_len: assert property (
    $rose(core_run) && mode_q inside {[3'h1:3'h3]} |-> edges_q >= SETTLE_CYC)
    else $error("core released before settle count");
  chk_ext_nodelay: assert property (
    live_q && !core_run && !slp_q && mode_q == OMSC_MODE_EXT |-> ##[0:12] core_run)
    else $error("external clock mode delayed start");
  chk_wake_run: assert property ($fell(slp_q) |-> ##[1:400] core_run)
    else $error("no run after wake");
  chk_sleep_stop: assert property (s_sleep_req |=> !core_run)
    else $error("core kept running in sleep");
  chk_fast_en: assert property (
    live_q && $stable({ifs_q, scs_q, tss_q}) |->
    fast_osc_enable == (ifs_q != 3'h0 && (scs_q || tss_q)))
    else $error("fast oscillator enable wrong");
  chk_int_src: assert property (
    live_q && $stable({scs_q, mode_q}) |->
    sys_clk_internal == (scs_q || (mode_q inside {3'h6, 3'h7})))
    else $error("clock source select wrong");
endmodule
bind omsc_top omsc_checker #(.SETTLE_CYC(SETTLE_CYC), .MODE_RST(MODE_RST)) omsc_checker_inst (.*);

// [dv/omsc_osc_model.sv]
`timescale 1ns/100ps
module omsc_osc_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fast_osc_enable,
  input  wire logic slow_osc_enable,
  output logic      crystal_input_pin,
  output logic      fast_osc_ready,
  output logic      slow_osc_ready,
  output logic      fast_osc_tick,
  output logic      slow_osc_tick
);
  logic [3:0] phase_q;
  logic [2:0] fwarm_q, swarm_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase_q <= 4'h0;
    else phase_q <= phase_q + 4'h1;
  end
  // Oscillators need a few cycles of warm-up after enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {fwarm_q, swarm_q} <= 6'h00;
    end else begin
      fwarm_q <= fast_osc_enable ? {fwarm_q[1:0], 1'b1} : 3'h0;
      swarm_q <= slow_osc_enable ? {swarm_q[1:0], 1'b1} : 3'h0;
    end
  end
  assign crystal_input_pin = phase_q[3];
  assign fast_osc_tick     = phase_q[0];
  assign slow_osc_tick     = phase_q[2:0] == 3'h7;
  assign fast_osc_ready    = fwarm_q[2];
  assign slow_osc_ready    = swarm_q[2];
endmodule

// [dv/omsc_tb.sv]
`timescale 1ns/100ps
module testbench;
  import omsc_pkg::*;
  localparam int SC = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        power_up_delay_done, sleep_enter, wake_req, crystal_input_pin;
  logic        fast_osc_ready, slow_osc_ready, fast_osc_tick, slow_osc_tick;
  logic        core_run, sys_clk_internal, fast_osc_enable, slow_osc_enable;
  logic [4:0]  trim_value;
  omsc_pad_t   clock_input_pad, crystal_output_pad;
  omsc_gain_t  gain_select;
  int          miscompares, num_checks, n;
  int          sels[4] = '{0, 5, 6, 7};
  omsc_top #(.SETTLE_CYC(SC)) omsc_top_inst (.*);
  omsc_osc_model omsc_osc_model_inst (.*);
  always #20 pclk = ~pclk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic lost;
    miscompares++;
    $display("BAD wait expected done seen timeout");
    final_report();
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    num_checks++;
    if (got !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) lost();
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, err);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    apb(1'b0, a, 32'h0, rdat, err);
    chk(nm, x, rdat & m);
  endtask
  task automatic wait_run(output int k);
    k = 0;
    while (core_run !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) lost();
  endtask
  task automatic half(output int k);
    logic v;
    repeat (3) begin
      v = crystal_output_pad.out;
      k = 0;
      while (crystal_output_pad.out === v && k < 300) begin
        @(posedge pclk);
        k++;
      end
    end
    if (k >= 300) lost();
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h00;
    {power_up_delay_done, sleep_enter, wake_req} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    power_up_delay_done <= 1'b1;
    wait_run(n);
    chk("settle_gap", 32'h1, 32'(n > (SC - 1) * 16 && n < SC * 16 + 8));
    rd("ctrl_rst", OMSC_CTRL_OFS, 32'hFFFFFFF1, 32'h60);
    rd("cfg_rst", OMSC_CFG_OFS, 32'hFFFFFFFF, 32'h2);
    rd("trim_rst", OMSC_TRIM_OFS, 32'hFFFFFFFF, 32'h0);
    rd("started", OMSC_CTRL_OFS, 32'h8, 32'h8);
    for (int m = 0; m < 8; m++) begin
      wr(OMSC_CFG_OFS, 32'(m));
      repeat (2) @(posedge pclk);
      chk("gain", (m > 0 && m < 4) ? 32'(m) : 32'h0, 32'(gain_select));
    end
    wr(OMSC_CFG_OFS, 32'h4);
    half(n);
    chk("rc_half", 32'h20, 32'(n));
    wr(OMSC_CFG_OFS, 32'h6);
    foreach (sels[i]) begin
      wr(OMSC_CTRL_OFS, 32'(sels[i] << 4));
      half(n);
      chk("int_half", sels[i] == 0 ? 32'h10 : 32'(4 << (7 - sels[i])), 32'(n));
    end
    wr(OMSC_CTRL_OFS, 32'h71);
    repeat (12) @(posedge pclk);
    rd("fast_stable", OMSC_CTRL_OFS, 32'h6, 32'h4);
    wr(OMSC_CTRL_OFS, 32'h01);
    repeat (12) @(posedge pclk);
    rd("fast_off", OMSC_CTRL_OFS, 32'h6, 32'h2);
    wr(OMSC_CTRL_OFS, 32'h60);
    wr(OMSC_TRIM_OFS, 32'hFFFFFFF0);
    rd("trim", OMSC_TRIM_OFS, 32'hFFFFFFFF, 32'h10);
    chk("trim_pin", 32'h10, 32'(trim_value));
    apb(1'b0, 8'h0C, 32'h0, rdat, err);
    chk("bad_err", 32'h1, 32'(err));
    chk("bad_data", 32'h0, rdat);
    for (int i = 0; i < 2; i++) begin
      wr(OMSC_CFG_OFS, i == 0 ? 32'h2 : 32'h0);
      sleep_enter <= 1'b1;
      @(posedge pclk);
      sleep_enter <= 1'b0;
      @(posedge pclk);
      chk("asleep", 32'h0, 32'(core_run));
      repeat (20) @(posedge pclk);
      wake_req <= 1'b1;
      repeat (6) @(posedge pclk);
      wake_req <= 1'b0;
      wait_run(n);
      chk("wake_fast", 32'(i), 32'(n < 20));
    end
    final_report();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    lost();
  end
endmodule
